// File: common/vdr_pkg.sv
package vdr_pkg;
  // Implemented identifier width and table depth
  localparam int VPE_IMPL_W = 6;
  localparam int VPE_CNT = 64;
  localparam int INTID_W = 16;
  // Doorbell number meaning none supplied
  localparam logic [15:0] NO_DOORBELL = 16'h03ff;
  // Capability: individual doorbells unsupported when 1
  localparam logic NO_INDIV_CAP = 1'b0;
  // Register byte offsets
  localparam logic [7:0] OFS_TYPE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_PTR = 8'h08;
  localparam logic [7:0] OFS_PEND = 8'h0c;
  localparam logic [7:0] OFS_DBNUM = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Field positions
  localparam int BIT_VALID = 31;
  localparam int BIT_ZERO = 30;
  localparam int BIT_DBREQ = 30;
  localparam int BIT_G1 = 29;
  localparam int BIT_G0 = 28;
  localparam int BIT_SGI = 27;
  localparam int BIT_EN = 26;
  localparam int BIT_GRP = 25;
  localparam int BIT_OP = 28;
  localparam int BIT_LIMITED = 4;
  localparam int BIT_NOINDIV = 8;
  localparam int BIT_RWP = 31;
  // Reset value of the configured width minus one
  localparam logic [3:0] CFGW_RST = 4'h5;
  // Commands
  typedef enum logic [1:0] {
    VDR_MAP_PE = 2'h0,
    VDR_PEND = 2'h1,
    VDR_ENABLE = 2'h2
  } vdr_cmd_t;
endpackage : vdr_pkg

// File: dv/vdr_residency_sva.sv
`timescale 1ns/10ps
module vdr_residency_sva
  import vdr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tbl_rd_req,
  input wire logic [VPE_IMPL_W-1:0] tbl_rd_idx,
  input wire logic tbl_rd_ack,
  input wire logic [31:0] tbl_rd_data,
  input wire logic [31:0] sched_cfg,
  input wire logic doorbell_valid,
  input wire logic [INTID_W-1:0] doorbell_intid,
  input wire logic db_clear_valid,
  input wire logic [INTID_W-1:0] db_clear_intid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Completed command and scheduling writes
  logic cmd_wr;
  logic sched_wr;
  logic unmapped;
  assign cmd_wr = psel && penable && pwrite && paddr == OFS_CMD;
  assign sched_wr = psel && penable && pwrite && paddr == OFS_PEND && pwdata[BIT_VALID];
  assign unmapped = (paddr > OFS_STAT) || (paddr[1:0] != 2'h0);
  // Fetch still waiting, and fetch answered
  sequence s_fetch_wait;
    tbl_rd_req && !tbl_rd_ack;
  endsequence
  sequence s_fetch_done;
    tbl_rd_req && tbl_rd_ack;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_db_cause: assert property (doorbell_valid |-> $past(cmd_wr) || $past(cmd_wr, 2))
    else $error("doorbell without command");
  a_db_pulse: assert property (doorbell_valid |=> !doorbell_valid)
    else $error("doorbell longer than one cycle");
  a_clr_cause: assert property (db_clear_valid |-> $past(sched_wr) || $past(sched_wr, 2))
    else $error("clear without scheduling");
  a_clr_pulse: assert property (db_clear_valid |=> !db_clear_valid)
    else $error("clear longer than one cycle");
  a_fetch_start: assert property ($rose(tbl_rd_req) |-> $past(sched_wr) || $past(sched_wr, 2))
    else $error("fetch without scheduling");
  a_fetch_hold: assert property (s_fetch_wait |=> tbl_rd_req && $stable(tbl_rd_idx))
    else $error("fetch dropped early");
  a_fetch_end: assert property (s_fetch_done |=> !tbl_rd_req && sched_cfg == $past(tbl_rd_data))
    else $error("fetch not closed or entry not cached");
  a_err_map: assert property (psel && !penable |=> pslverr == $past(unmapped))
    else $error("slave error wrong");
endmodule : vdr_residency_sva
bind vdr_residency vdr_residency_sva u_sva (.*);

// File: dv/vdr_residency_tb_top.sv
`timescale 1ns/10ps
module vdr_residency_tb_top;
  import vdr_pkg::*;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, tbl_rd_data, sched_cfg, seed = 32'hce33;
  logic pready, pslverr, tbl_rd_req, tbl_rd_ack, doorbell_valid, db_clear_valid;
  logic [1:0] ack_delay = 0;
  logic [VPE_IMPL_W-1:0] tbl_rd_idx;
  logic [15:0] doorbell_intid, db_clear_intid, dd, de, di;
  logic [15:0] db_q[$], clr_q[$]; // Expected doorbells and clears
  int n_errors = 0, samples_checked = 0;
  vdr_residency dut (.*);
  vdr_tbl_model u_tbl (.*);
  always #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask : rdc
  // Write then read back to back, no idle edge between
  task automatic wr_rd(input logic [7:0] aw, input logic [31:0] d, input logic [7:0] ar,
                       output logic [31:0] r);
    psel <= 1;
    pwrite <= 1;
    paddr <= aw;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    penable <= 0;
    pwrite <= 0;
    paddr <= ar;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask : wr_rd
  task automatic cmd(input logic [1:0] op, input logic sgi, input logic en, input logic [15:0] id);
    wr(OFS_CMD, {2'h0, op, sgi, en, 1'b1, 9'h0, id});
  endtask : cmd
  // Wait for the entry fetch to close, then check the cache
  task automatic fetch_chk(input logic [5:0] id);
    @(negedge ref_clk);
    while (tbl_rd_req !== 1'b0) begin
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    chk("sched_cfg", {16'h5eed, 10'h0, id}, sched_cfg);
    @(posedge ref_clk);
  endtask : fetch_chk
  task automatic complete_run;
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // Output watcher against the expected notes
  always @(negedge ref_clk) begin
    if (rst_n && doorbell_valid === 1'b1) begin
      if (db_q.size() == 0) chk("doorbell_valid", 32'h0, 32'h1);
      else chk("doorbell_intid", {16'h0, db_q.pop_front()}, {16'h0, doorbell_intid});
    end
    if (rst_n && db_clear_valid === 1'b1) begin
      if (clr_q.size() == 0) chk("db_clear_valid", 32'h0, 32'h1);
      else chk("db_clear_intid", {16'h0, clr_q.pop_front()}, {16'h0, db_clear_intid});
    end
  end
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    rdc(OFS_TYPE, 32'h15, 0);
    rdc(OFS_CTRL, {28'h0, CFGW_RST}, 0);
    rdc(OFS_DBNUM, 32'h3ff, 0);
    rdc(8'h1c, 32'h0, 1);
    wr(OFS_PTR, 32'h8000_0100);
    seed = xs(seed);
    dd = {4'h2, seed[11:0]};
    seed = xs(seed);
    de = {4'h3, seed[11:0]};
    seed = xs(seed);
    di = {4'h4, seed[11:0]};
    wr(OFS_DBNUM, {16'h0, dd});
    cmd(0, 0, 1, 3);
    wr(OFS_DBNUM, {16'h0, de});
    cmd(0, 0, 1, 5);
    wr(OFS_DBNUM, {16'h0, NO_DOORBELL});
    db_q.push_back(dd);
    cmd(1, 0, 1, 3);
    cmd(1, 0, 1, 3);
    cmd(1, 0, 0, 5);
    db_q.push_back(de);
    cmd(2, 0, 1, 5);
    wr(OFS_DBNUM, {16'h0, di});
    cmd(1, 1, 1, 5);
    db_q.push_back(di);
    cmd(1, 0, 1, 3);
    wr(OFS_DBNUM, {16'h0, NO_DOORBELL});
    cmd(1, 0, 1, 16'h40);
    rdc(OFS_STAT, 32'h1, 0);
    wr(OFS_STAT, 32'h1);
    wr(OFS_CTRL, 32'h3);
    cmd(1, 0, 1, 16'h10);
    rdc(OFS_STAT, 32'h1, 0);
    wr(OFS_STAT, 32'h1);
    wr(OFS_CTRL, {28'h0, CFGW_RST});
    rdc(OFS_STAT, 32'h0, 0);
    ack_delay <= 2'h2;
    clr_q.push_back(dd);
    wr(OFS_PEND, 32'hf000_0003);
    fetch_chk(6'h3);
    cmd(1, 0, 1, 3);
    wr(OFS_PEND, 32'h3000_0003);
    cmd(1, 0, 1, 3);
    wr(OFS_DBNUM, {16'h0, di});
    db_q.push_back(di);
    cmd(1, 0, 1, 3);
    wr(OFS_DBNUM, {16'h0, NO_DOORBELL});
    ack_delay <= 2'h0;
    clr_q.push_back(de);
    wr(OFS_PEND, 32'hf000_0005);
    fetch_chk(6'h5);
    wr(OFS_PEND, 32'h7000_0005);
    db_q.push_back(de);
    cmd(1, 0, 1, 5);
    wr_rd(OFS_PTR, 32'h0, OFS_CTRL, r);
    chk("write_pending", 32'h1, {31'h0, r[BIT_RWP]});
    n = 0;
    do begin
      apb(0, OFS_CTRL, 32'h0, r, e);
      n++;
    end while (r[BIT_RWP] !== 1'b0 && n < 20);
    chk("write_pending", 32'h0, {31'h0, r[BIT_RWP]});
    rdc(OFS_PTR, 32'h0, 0);
    wr(OFS_PTR, 32'hc000_0200);
    rdc(OFS_PTR, 32'hc000_0200, 0);
    clr_q.push_back(dd);
    wr(OFS_PEND, 32'hf000_0003);
    @(negedge ref_clk);
    chk("tbl_rd_req", 32'h0, {31'h0, tbl_rd_req});
    repeat (4) @(posedge ref_clk);
    chk("notes left", 32'h0, 32'(db_q.size() + clr_q.size()));
    complete_run();
  end
endmodule : vdr_residency_tb_top

// File: dv/vdr_tbl_model.sv
`timescale 1ns/10ps
module vdr_tbl_model
  import vdr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tbl_rd_req,
  input wire logic [VPE_IMPL_W-1:0] tbl_rd_idx,
  input wire logic [1:0] ack_delay, // Wait cycles before answering
  output logic tbl_rd_ack,
  output logic [31:0] tbl_rd_data
);
  logic [1:0] wait_cnt; // Cycles waited so far
  logic [31:0] junk; // Toggling pattern off the answer
  // Read-only table indexed by identifier
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 2'h0;
      junk <= 32'h5a5a_a5a5;
      tbl_rd_ack <= 1'b0;
      tbl_rd_data <= 32'h0;
    end else begin
      junk <= ~junk;
      tbl_rd_ack <= 1'b0;
      tbl_rd_data <= junk;
      if (tbl_rd_req && !tbl_rd_ack) begin
        if (wait_cnt == ack_delay) begin
          tbl_rd_ack <= 1'b1;
          tbl_rd_data <= {16'h5eed, 10'h0, tbl_rd_idx};
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule : vdr_tbl_model

// File: rtl/vdr_drain.sv
`timescale 1ns/10ps
module vdr_drain (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ptr_clear,
  input wire logic rd_issue,
  input wire logic rd_done,
  input wire logic cache_vld,
  output logic write_pending_flag
);
  import vdr_pkg::*;

  logic [1:0] outstanding; // Table reads in flight
  logic [1:0] next_outstanding;
  logic drained; // Nothing in flight, nothing cached

  assign next_outstanding = outstanding + 2'(rd_issue) - 2'(rd_done);
  assign drained = (next_outstanding == 2'h0) && !cache_vld;

  // Count reads in flight
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      outstanding <= 2'h0;
    end else begin
      outstanding <= next_outstanding;
    end
  end

  // Flag set on teardown; set wins over drain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_pending_flag <= 1'b0;
    end else if (ptr_clear) begin
      write_pending_flag <= 1'b1;
    end else if (drained) begin
      write_pending_flag <= 1'b0;
    end
  end
endmodule : vdr_drain

// File: rtl/vdr_residency.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module vdr_residency (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tbl_rd_req,
  output logic [vdr_pkg::VPE_IMPL_W-1:0] tbl_rd_idx,
  input wire logic tbl_rd_ack,
  input wire logic [31:0] tbl_rd_data,
  output logic [31:0] sched_cfg,
  output logic doorbell_valid,
  output logic [vdr_pkg::INTID_W-1:0] doorbell_intid,
  output logic db_clear_valid,
  output logic [vdr_pkg::INTID_W-1:0] db_clear_intid
);
  import vdr_pkg::*;

  localparam int IW = VPE_IMPL_W;

  // Identifier fits the configured width
  function automatic logic id_fits(input logic [15:0] id, input logic [3:0] wm1);
    logic [16:0] lim;
    lim = 17'h00002 << wm1;
    id_fits = {1'b0, id} < lim;
  endfunction : id_fits

  // Software-visible state
  logic [3:0] cfg_wm1; // Configured width minus one
  logic ptr_valid; // Table pointer valid
  logic ptr_zero; // Table known all zero
  logic [15:0] ptr_base; // Table location
  logic pend_valid; // A PE is scheduled
  logic pend_dbreq; // Last written doorbell request
  logic pend_g0; // Group 0 enable
  logic pend_g1; // Group 1 enable
  logic [IW-1:0] pend_id; // Scheduled identifier
  logic [15:0] dbnum; // Event doorbell operand
  logic cmd_error; // Sticky command error
  logic write_pending_flag; // Teardown in progress

  // Per-PE state
  logic [15:0] def_db [VPE_CNT]; // Default doorbell
  logic [VPE_CNT-1:0] mapped; // PE created
  logic [VPE_CNT-1:0] dbreq; // Request at deschedule
  logic [VPE_CNT-1:0] raised; // Default already pended
  logic [VPE_CNT-1:0] ever_sched; // Scheduled at least once
  logic [VPE_CNT-1:0] grp0_en; // Captured group 0
  logic [VPE_CNT-1:0] grp1_en; // Captured group 1

  // Table cache
  logic cache_vld;

  // Bus decode
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire hit_type = paddr == OFS_TYPE;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_ptr = paddr == OFS_PTR;
  wire hit_pend = paddr == OFS_PEND;
  wire hit_dbnum = paddr == OFS_DBNUM;
  wire hit_cmd = paddr == OFS_CMD;
  wire hit_stat = paddr == OFS_STAT;
  wire mapped_addr = hit_type || hit_ctrl || hit_ptr || hit_pend
                     || hit_dbnum || hit_cmd || hit_stat;

  // Identification word
  wire [3:0] impl_wm1 = 4'(IW - 1);
  wire [31:0] type_word = {23'h0, NO_INDIV_CAP, 3'h0,
                           (impl_wm1 != 4'hf), impl_wm1};

  // Read mux
  wire [31:0] rd_word =
    hit_type ? type_word :
    hit_ctrl ? {write_pending_flag, 27'h0, cfg_wm1} :
    hit_ptr ? {ptr_valid, ptr_zero, 14'h0, ptr_base} :
    hit_pend ? {pend_valid, pend_dbreq, pend_g1, pend_g0,
                12'h0, 16'(pend_id)} :
    hit_dbnum ? {16'h0, dbnum} :
    hit_stat ? {31'h0, cmd_error} : 32'h0;

  // Write strobes
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_ptr = wr && hit_ptr && !write_pending_flag;
  wire wr_pend = wr && hit_pend;
  wire wr_cmd = wr && hit_cmd;
  wire wr_stat = wr && hit_stat;
  wire ptr_clear = wr_ptr && ptr_valid && !pwdata[BIT_VALID];

  // Configured width never above implemented
  wire [3:0] next_cfg = (pwdata[3:0] > impl_wm1) ? impl_wm1 : pwdata[3:0];

  // Command fields
  wire [1:0] op = pwdata[BIT_OP+1:BIT_OP];
  wire [15:0] cid = pwdata[15:0];
  wire [IW-1:0] cidx = cid[IW-1:0];
  wire cid_ok = id_fits(cid, cfg_wm1);
  wire cmd_go = wr_cmd && cid_ok;
  wire cmd_bad = wr_cmd && (!cid_ok || op == 2'h3);
  wire c_sgi = pwdata[BIT_SGI];
  wire c_en = pwdata[BIT_EN];
  wire c_grp = pwdata[BIT_GRP];

  // Pending-base write fields
  wire [15:0] pid = pwdata[15:0];
  wire pid_ok = id_fits(pid, cfg_wm1);
  wire [IW-1:0] pidx = pid[IW-1:0];
  wire do_sched = wr_pend && pwdata[BIT_VALID] && pid_ok;
  wire do_desched = wr_pend && pend_valid && !pwdata[BIT_VALID];

  // Event doorbell number, forced when unsupported
  wire [15:0] ev_db = NO_INDIV_CAP ? NO_DOORBELL : dbnum;

  // Target scheduled here
  wire tgt_sched = pend_valid && pend_id == cidx;

  // Group enable seen by the target
  wire grp_on = !ever_sched[cidx] ? 1'b1 :
                (c_grp ? grp1_en[cidx] : grp0_en[cidx]);

  // Individual doorbell: pending event, unscheduled
  wire indiv_db = cmd_go && op == VDR_PEND && !NO_INDIV_CAP
                  && !c_sgi && ev_db != NO_DOORBELL
                  && !tgt_sched;

  // Interrupt that may wake the default doorbell
  wire def_cause = cmd_go && ((op == VDR_PEND && !indiv_db
                   && (c_sgi || ev_db == NO_DOORBELL))
                   || op == VDR_ENABLE);

  // Default doorbell: every condition together
  wire dflt_db = def_cause && c_en && grp_on
                 && !tgt_sched && dbreq[cidx]
                 && mapped[cidx] && def_db[cidx] != NO_DOORBELL
                 && !raised[cidx];

  // Table fetch may start only on a live pointer
  wire fetch_start = do_sched && ptr_valid && !ptr_zero
                     && !(wr_ptr && !pwdata[BIT_VALID]);
  wire rd_done = tbl_rd_req && tbl_rd_ack;

  // Bus answer registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      pready <= 1'b1;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : rd_word;
      pslverr <= !mapped_addr;
      pready <= 1'b1;
    end
  end

  // Configured width
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wm1 <= CFGW_RST;
    end else if (wr_ctrl) begin
      cfg_wm1 <= next_cfg;
    end
  end

  // Table pointer register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_valid <= 1'b0;
      ptr_zero <= 1'b0;
      ptr_base <= 16'h0;
    end else if (ptr_clear) begin
      // Other fields go to a fixed value
      ptr_valid <= 1'b0;
      ptr_zero <= 1'b0;
      ptr_base <= 16'h0;
    end else if (wr_ptr) begin
      ptr_valid <= pwdata[BIT_VALID];
      ptr_zero <= pwdata[BIT_ZERO];
      ptr_base <= pwdata[15:0];
    end
  end

  // Pending-base register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_valid <= 1'b0;
      pend_dbreq <= 1'b0;
      pend_g0 <= 1'b0;
      pend_g1 <= 1'b0;
      pend_id <= '0;
    end else if (wr_pend) begin
      pend_valid <= do_sched;
      pend_dbreq <= pwdata[BIT_DBREQ];
      pend_g0 <= pwdata[BIT_G0];
      pend_g1 <= pwdata[BIT_G1];
      pend_id <= pidx;
    end
  end

  // Doorbell operand
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dbnum <= NO_DOORBELL;
    end else if (wr && hit_dbnum) begin
      dbnum <= pwdata[15:0];
    end
  end

  // Sticky error; a new error beats the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_error <= 1'b0;
    end else if (cmd_bad) begin
      cmd_error <= 1'b1;
    end else if (wr_stat && pwdata[0]) begin
      cmd_error <= 1'b0;
    end
  end

  // Per-PE state, one slice per identifier
  genvar g;
  generate
    for (g = 0; g < VPE_CNT; g++) begin : g_pe
      wire map_me = cmd_go && op == VDR_MAP_PE && cidx == IW'(g);
      wire sch_me = do_sched && pidx == IW'(g);
      wire des_me = do_desched && pend_id == IW'(g);
      wire ring_me = dflt_db && cidx == IW'(g);
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          def_db[g] <= NO_DOORBELL;
          mapped[g] <= 1'b0;
          dbreq[g] <= 1'b0;
          raised[g] <= 1'b0;
          ever_sched[g] <= 1'b0;
          grp0_en[g] <= 1'b0;
          grp1_en[g] <= 1'b0;
        end else if (map_me) begin
          // Creation acts as deschedule with request
          def_db[g] <= ev_db;
          mapped[g] <= 1'b1;
          dbreq[g] <= 1'b1;
          raised[g] <= 1'b0;
          ever_sched[g] <= 1'b0;
        end else if (sch_me) begin
          raised[g] <= 1'b0;
          ever_sched[g] <= 1'b1;
          grp0_en[g] <= pwdata[BIT_G0];
          grp1_en[g] <= pwdata[BIT_G1];
        end else if (des_me) begin
          dbreq[g] <= pwdata[BIT_DBREQ];
          raised[g] <= 1'b0;
        end else if (ring_me) begin
          raised[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // Doorbell delivery to the processing element
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      doorbell_valid <= 1'b0;
      doorbell_intid <= '0;
    end else begin
      doorbell_valid <= indiv_db || dflt_db;
      if (indiv_db) begin
        doorbell_intid <= ev_db;
      end else if (dflt_db) begin
        doorbell_intid <= def_db[cidx];
      end
    end
  end

  // Clear the default doorbell on scheduling
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      db_clear_valid <= 1'b0;
      db_clear_intid <= '0;
    end else begin
      db_clear_valid <= do_sched && def_db[pidx] != NO_DOORBELL;
      if (do_sched) begin
        db_clear_intid <= def_db[pidx];
      end
    end
  end

  // Table entry fetch for the scheduled PE
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_rd_req <= 1'b0;
      tbl_rd_idx <= '0;
    end else if (fetch_start && !tbl_rd_req) begin
      tbl_rd_req <= 1'b1;
      tbl_rd_idx <= pidx;
    end else if (rd_done) begin
      tbl_rd_req <= 1'b0;
    end
  end

  // Cached entry; dropped when the pointer goes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cache_vld <= 1'b0;
      sched_cfg <= 32'h0;
    end else if (ptr_clear || !ptr_valid) begin
      cache_vld <= 1'b0;
      sched_cfg <= 32'h0;
    end else if (do_sched && ptr_zero) begin
      cache_vld <= 1'b1;
      sched_cfg <= 32'h0;
    end else if (rd_done) begin
      cache_vld <= 1'b1;
      sched_cfg <= tbl_rd_data;
    end
  end

  // Teardown drain tracking
  vdr_drain u_drain (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ptr_clear(ptr_clear),
    .rd_issue(fetch_start && !tbl_rd_req),
    .rd_done(rd_done),
    .cache_vld(cache_vld),
    .write_pending_flag(write_pending_flag)
  );
endmodule : vdr_residency
